// ### hw/acs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "acs_map.svh"

module acs_sequencer #(
  parameter int NUM_CH = `ACS_NUM_CH
) (
  input  wire logic                core_clk_i,   // system clock 100 MHz
  input  wire logic                rstn_i,       // async reset, active low
  input  wire logic                cmd_valid_i,  // command strobe, one cycle
  input  wire acs_pkg::acs_cmd_t   cmd_i,        // command word
  output logic                     cmd_ready_o,  // idle, command may be taken
  output logic [NUM_CH-1:0]        relay_o,      // relay closed per channel
  output logic                     meas_trig_o,  // voltmeter trigger pulse
  input  wire logic                meas_done_i,  // voltmeter result strobe
  input  wire logic [23:0]         meas_value_i, // voltmeter result
  output logic                     result_valid_o, // result pulse
  output acs_pkg::acs_result_t     result_o      // channel and value reported
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_BREAK, ST_WAIT} acs_state_t;

  // one step of the current channel, at the channel field width
  localparam logic [`ACS_CH_W-1:0] CH_STEP = {{(`ACS_CH_W-1){1'b0}}, 1'b1};

  // command sequencing
  acs_state_t              state_q, state_d;
  logic [`ACS_CH_W-1:0]    first_q, first_d;
  logic [`ACS_CH_W-1:0]    last_q, last_d;
  logic [`ACS_CH_W-1:0]    cur_q, cur_d;
  logic                    list_q, list_d;
  logic                    trig_q, trig_d;
  logic                    rdy_q, rdy_d;

  // relay bank requests, decoded once and applied in every channel
  logic                    rly_clr;
  logic                    rly_set;
  logic [`ACS_CH_W-1:0]    rly_ch;
  logic [NUM_CH-1:0]       relay_q;

  // measurement result
  logic                    rv_q, rv_d;
  acs_pkg::acs_result_t    res_q, res_d;

  // step decode; equal bounds count as a downward scan that is already done
  logic                    step_move;
  logic                    step_up;

  assign step_move = (cur_q != last_q);
  assign step_up   = (last_q > first_q);

  // ---------------------------------------------------------------
  // command sequencing
  // ---------------------------------------------------------------
  // a command is taken only in idle; one sent while busy is dropped
  always_comb begin
    state_d = state_q;
    first_d = first_q;
    last_d  = last_q;
    cur_d   = cur_q;
    list_d  = list_q;
    trig_d  = 1'b0;

    // no relay request unless a command below asks for one
    rly_clr = 1'b0;
    rly_set = 1'b0;
    rly_ch  = cmd_i.chan;
    unique case (state_q)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          unique case (cmd_i.op)
            acs_pkg::ACS_OP_FIRST: begin
              // bounds only: the relay requests stay low
              first_d = cmd_i.chan;
              cur_d   = cmd_i.chan;
            end
            acs_pkg::ACS_OP_LAST: begin
              last_d = cmd_i.chan;
            end
            acs_pkg::ACS_OP_STEP: begin
              // a step at the last bound is refused and changes nothing
              if (step_move) begin
                if (step_up) begin
                  cur_d = cur_q + CH_STEP;
                end else begin
                  cur_d = cur_q - CH_STEP;
                end
                rly_clr = 1'b1;
                state_d = ST_BREAK;
              end
            end
            acs_pkg::ACS_OP_CLOSE: begin
              // the first item of a list opens whatever was closed before
              rly_clr = !list_q;
              rly_set = 1'b1;
              list_d  = !cmd_i.list_end;
              cur_d   = cmd_i.chan;
              if (cmd_i.list_end && !list_q) begin
                trig_d  = 1'b1;
                state_d = ST_WAIT;
              end
            end
            acs_pkg::ACS_OP_INPUT: begin
              rly_set = 1'b1;
              cur_d   = cmd_i.chan;
              trig_d  = 1'b1;
              state_d = ST_WAIT;
            end
            acs_pkg::ACS_OP_OPEN_ALL: begin
              // also abandons a list that was never finished
              rly_clr = 1'b1;
              list_d  = 1'b0;
            end
            default: begin
              // codes above the last command are ignored
            end
          endcase
        end
      end
      ST_BREAK: begin
        // the bank was fully open for one cycle, so break comes before make
        rly_clr = 1'b1;
        rly_set = 1'b1;
        rly_ch  = cur_q;
        state_d = ST_IDLE;
      end
      ST_WAIT: begin
        // commands are refused until the voltmeter answers
        if (meas_done_i) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // ready follows the next state, so no busy cycle shows ready
    rdy_d = (state_d == ST_IDLE);
  end

  // bounds only change on their own set commands
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      first_q <= `ACS_FIRST_RST;
      last_q  <= `ACS_LAST_RST;
      cur_q   <= `ACS_FIRST_RST;
      list_q  <= 1'b0;
      trig_q  <= 1'b0;
      rdy_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      first_q <= first_d;
      last_q  <= last_d;
      cur_q   <= cur_d;
      list_q  <= list_d;
      trig_q  <= trig_d;
      rdy_q   <= rdy_d;
    end
  end

  // ---------------------------------------------------------------
  // relay bank
  // ---------------------------------------------------------------
  // one flop per channel; a channel number outside the bank matches no flop,
  // so such a command closes nothing but is still measured
  for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_relay
    logic bit_q;
    logic bit_d;

    always_comb begin
      bit_d = bit_q & ~rly_clr;
      if (rly_set && (int'(rly_ch) == gi)) begin
        bit_d = 1'b1;
      end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        bit_q <= 1'b0;
      end else begin
        bit_q <= bit_d;
      end
    end

    assign relay_q[gi] = bit_q;
  end : g_relay

  // ---------------------------------------------------------------
  // measurement result
  // ---------------------------------------------------------------
  // result_o holds until the next answer, so a slow host still finds it
  always_comb begin
    rv_d  = 1'b0;
    res_d = res_q;
    if ((state_q == ST_WAIT) && meas_done_i) begin
      rv_d        = 1'b1;
      res_d.chan  = cur_q;
      res_d.value = meas_value_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rv_q  <= 1'b0;
      res_q <= '0;
    end else begin
      rv_q  <= rv_d;
      res_q <= res_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // every output is a flop; nothing combinational reaches a pin
  assign cmd_ready_o    = rdy_q;
  assign relay_o        = relay_q;
  assign meas_trig_o    = trig_q;
  assign result_valid_o = rv_q;
  assign result_o       = res_q;

endmodule : acs_sequencer
`default_nettype wire

// ### pkg/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_CH_W      7
`define ACS_NUM_CH    100
`define ACS_VAL_W     24
`define ACS_FIRST_RST 7'h00
`define ACS_LAST_RST  7'h00
`endif

// ### pkg/acs_pkg.sv
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_OP_FIRST,
    ACS_OP_LAST,
    ACS_OP_STEP,
    ACS_OP_CLOSE,
    ACS_OP_INPUT,
    ACS_OP_OPEN_ALL
  } acs_op_t;

  typedef struct packed {
    acs_op_t     op;
    logic        list_end;
    logic [6:0]  chan;
  } acs_cmd_t;

  typedef struct packed {
    logic [6:0]  chan;
    logic [23:0] value;
  } acs_result_t;
endpackage : acs_pkg

// ### tb/acs_meter_model.sv
`timescale 1ns/100ps
`default_nettype none
module acs_meter_model (
  input  wire logic        core_clk_i,   // clock
  input  wire logic        rstn_i,       // reset, active low
  input  wire logic        meas_trig_o,  // trigger from sequencer
  input  wire logic [3:0]  lat_i,        // answer delay
  input  wire logic [23:0] val_i,        // value to report
  output logic             meas_done_i,  // result strobe
  output logic [23:0]      meas_value_i  // result
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk_i or negedge rstn_i) if (!rstn_i) cnt_q <= 4'h0;
    else if (meas_trig_o) cnt_q <= lat_i + 4'h1;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  assign meas_done_i  = cnt_q == 4'h1;
  // value is junk outside the strobe so a late sample cannot pass
  assign meas_value_i = meas_done_i ? val_i : ~val_i;
endmodule : acs_meter_model
`default_nettype wire

// ### tb/acs_seq_chk.sv
`timescale 1ns/100ps
`default_nettype none
module acs_seq_chk #(parameter int NUM_CH = 100) (
  input wire logic              core_clk_i, rstn_i, cmd_valid_i, cmd_ready_o,
  input wire logic              meas_trig_o, meas_done_i, result_valid_o,
  input wire acs_pkg::acs_cmd_t cmd_i,
  input wire logic [NUM_CH-1:0] relay_o,
  input wire logic [23:0]       meas_value_i,
  input wire acs_pkg::acs_result_t result_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire tk = cmd_valid_i && cmd_ready_o;
  wire cl = tk && cmd_i.op == acs_pkg::ACS_OP_CLOSE;
  // single close only outside a list, so track list membership
  logic in_q;
  always_ff @(posedge core_clk_i or negedge rstn_i) if (!rstn_i) in_q <= 1'b0;
    else if (cl) in_q <= !cmd_i.list_end;
    else if (tk && cmd_i.op == acs_pkg::ACS_OP_OPEN_ALL) in_q <= 1'b0;
  bound_keep_a: assert property (tk && cmd_i.op inside {acs_pkg::ACS_OP_FIRST,
    acs_pkg::ACS_OP_LAST} |=> $stable(relay_o)) else $error("bound cmd moved relays");
  step_open_a: assert property (tk && cmd_i.op == acs_pkg::ACS_OP_STEP |=>
    (relay_o == '0 || $stable(relay_o)) ##1 $countones(relay_o) <= 1) else $error("bad step");
  trig_single_a: assert property (cl && cmd_i.list_end && !in_q |=> meas_trig_o)
    else $error("no trigger");
  close_relay_a: assert property (cl && cmd_i.list_end && !in_q && cmd_i.chan < NUM_CH
    |=> relay_o[$past(cmd_i.chan)]) else $error("relay not closed");
  list_quiet_a: assert property (cl && !cmd_i.list_end |=> !meas_trig_o)
    else $error("list item measured");
  input_trig_a: assert property (tk && cmd_i.op == acs_pkg::ACS_OP_INPUT |=> meas_trig_o)
    else $error("input not measured");
  result_a: assert property (meas_done_i && !cmd_ready_o |=> result_valid_o &&
    result_o.value == $past(meas_value_i)) else $error("result lost");
  result_hold_a: assert property (!result_valid_o |-> $stable(result_o))
    else $error("result moved");
endmodule : acs_seq_chk
`default_nettype wire

// ### tb/test_analog_channel_scan_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin \
  n_tests++; \
  if ((e) !== (s)) begin \
    n_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, s); \
  end \
end
module test_analog_channel_scan_sequencer;
  logic core_clk_i = 1'b0, rstn_i = 1'b0, cmd_valid_i = 1'b0, cmd_ready_o, meas_trig_o;
  logic meas_done_i, result_valid_o;
  logic [99:0] relay_o;
  logic [23:0] meas_value_i, val = 24'h0;
  logic [3:0] lat = 4'h2;
  logic [31:0] seed = 32'h8f54;
  acs_pkg::acs_cmd_t cmd_i = '0;
  acs_pkg::acs_result_t result_o;
  int n_errors = 0, n_tests = 0, a, b, e, x, y;
  always #5 core_clk_i = ~core_clk_i;
  acs_sequencer #(.NUM_CH(100)) dut (.core_clk_i, .rstn_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
    .relay_o, .meas_trig_o, .meas_done_i, .meas_value_i, .result_valid_o, .result_o);
  acs_meter_model vm (.core_clk_i, .rstn_i, .meas_trig_o, .lat_i(lat), .val_i(val),
    .meas_done_i, .meas_value_i);
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[15:0]);
  endfunction : xs
  function automatic logic [99:0] oh(int c); return 100'h1 << c; endfunction : oh
  task automatic send(acs_pkg::acs_op_t op, logic le, int c);
    @(negedge core_clk_i);
    while (cmd_ready_o !== 1'b1) @(negedge core_clk_i);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{op, le, 7'(c)};
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
  endtask : send
  task automatic wres(int c);
    for (int i = 0; i < 40 && result_valid_o !== 1'b1; i++) @(negedge core_clk_i);
    `CHK("result valid", 1'b1, result_valid_o)
    `CHK("result", {7'(c), val}, result_o)
  endtask : wres
  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      a = xs() % 90 + 5;
      b = k[0] ? a - xs() % 5 - 1 : a + xs() % 5 + 1;
      send(acs_pkg::ACS_OP_OPEN_ALL, 1'b1, 0);
      send(acs_pkg::ACS_OP_FIRST, 1'b1, a);
      send(acs_pkg::ACS_OP_LAST, 1'b1, b);
      @(negedge core_clk_i);
      `CHK("bound relays", 100'h0, relay_o)
      e = a;
      for (int s = 0; s < 7; s++) begin
        send(acs_pkg::ACS_OP_STEP, 1'b1, 0);
        if (e != b) e += (b > a) ? 1 : -1;
        repeat (2) @(negedge core_clk_i);
        `CHK("step relay", oh(e), relay_o)
      end
      $display("step test %0d done", k);
    end
    for (int k = 0; k < 3; k++) begin
      x = xs() % 100;
      y = (x + 1 + xs() % 98) % 100;
      @(posedge core_clk_i);
      val <= 24'(xs());
      lat <= 4'(xs() % 8);
      send(acs_pkg::ACS_OP_CLOSE, 1'b1, x);
      wres(x);
      `CHK("single relay", oh(x), relay_o)
      send(acs_pkg::ACS_OP_CLOSE, 1'b0, x);
      send(acs_pkg::ACS_OP_CLOSE, 1'b1, y);
      repeat (2) @(negedge core_clk_i);
      `CHK("list relay", oh(x) | oh(y), relay_o)
      @(posedge core_clk_i);
      val <= 24'(xs());
      send(acs_pkg::ACS_OP_INPUT, 1'b1, x);
      wres(x);
      $display("close test %0d done", k);
    end
    // a channel beyond the bank closes nothing but is still measured
    send(acs_pkg::ACS_OP_OPEN_ALL, 1'b1, 0);
    send(acs_pkg::ACS_OP_INPUT, 1'b1, 120);
    wres(120);
    `CHK("no relay", 100'h0, relay_o)
    $display("corner test done");
    complete_run();
  end
endmodule : test_analog_channel_scan_sequencer
bind acs_sequencer acs_seq_chk #(.NUM_CH(NUM_CH)) chk (.core_clk_i, .rstn_i, .cmd_valid_i,
  .cmd_ready_o, .meas_trig_o, .meas_done_i, .result_valid_o, .cmd_i, .relay_o, .meas_value_i,
  .result_o);
`default_nettype wire
